// file: common/mpd_pkg.sv
// package for the motor parameter decode and start-path selector
// assumes one core clock; all configuration arrives as plain ports
// Notes on behaviour
// RL1 - resistance code 0x00 is zero ohm, 0x01 one step, 0x7F the maximum
// RL2 - bemf code is phase-to-phase back-emf per electrical velocity, fed to drive logic
// RL3 - bemf linear value is mantissa bits 3..0 shifted left by exponent bits 6..4
// RL4 - largest bemf code 0x7F decodes to linear 1920
// RL5 - smallest nonzero bemf code 0x01 decodes to linear one
// RL6 - software writes only valid codes; nonzero exponent needs mantissa top bit set
// RL7 - at start classify motor stationary, forward or reverse; distinct path each; with speed probe disabled the code skips this and takes the stationary path
// RL8 - stationary motor: set commutation from rotor position before driving
// RL9 - probing derives rotor position from winding inductance variation
// RL10 - align drives one chosen phase, then commutation starts from that position
// RL11 - forward spinning fast enough and enabled: resynchronise straight to closed loop
// RL12 - resistance linear value uses same mantissa and shift encoding, 9.67 milliohm lsb
// RL13 - resync only when speed probe enabled and reports forward rotation
// RL14 - stationary start uses probing if probe threshold nonzero, else align
// RL15 - codes decode combinationally from current configuration, used at next start
package mpd_pkg;
    localparam int CODE_W = 7;
    localparam int LIN_W = 11;
    localparam int MANT_LSB = 0;
    localparam int MANT_W = 4;
    localparam int EXP_LSB = 4;
    localparam int EXP_W = 3;
    localparam int THR_W = 4;
    localparam logic [THR_W-1:0] THR_OFF = 4'h0;
    localparam logic [CODE_W-1:0] CODE_MAX = 7'h7F;
    localparam logic [LIN_W-1:0] LIN_MAX = 11'h780;
    localparam logic [1:0] PHASE_RST = 2'h0;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_SPEED = 3'b001,
        ST_PROBE = 3'b010,
        ST_ALIGN = 3'b011,
        ST_RESYNC = 3'b100,
        ST_REVERSE = 3'b101,
        ST_RUN = 3'b110
    } mpd_state_e;

    typedef enum logic [1:0] {
        PATH_NONE = 2'b00,
        PATH_STILL = 2'b01,
        PATH_FWD = 2'b10,
        PATH_REV = 2'b11
    } mpd_path_e;
endpackage

// file: design/mpd_code_decode.sv
// mantissa-and-shift decoder for one 7-bit motor code
// assumes software writes only valid codes
`timescale 1ns/10ps
`default_nettype none
module mpd_code_decode
    import mpd_pkg::*;
(
    // code in
    input wire logic [CODE_W-1:0] code_in,
    // linear value out
    output logic [LIN_W-1:0] lin_out
);
    logic [LIN_W-1:0] mant;
    logic [EXP_W-1:0] shamt;
    always_comb begin
        mant = {{(LIN_W-MANT_W){1'b0}}, code_in[MANT_LSB +: MANT_W]};
        shamt = code_in[EXP_LSB +: EXP_W];
        // RL3 mantissa shifted left
        lin_out = mant << shamt;
    end
endmodule
`default_nettype wire

// file: design/mpd_sync2.sv
// two flip-flop level synchroniser
// assumes asynchronous active-low reset
`timescale 1ns/10ps
`default_nettype none
module mpd_sync2 (
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // level
    input wire logic d_in,
    output logic q_out
);
    logic meta_r;
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            meta_r <= 1'b0;
            q_out <= 1'b0;
        end else begin
            meta_r <= d_in;
            q_out <= meta_r;
        end
    end
endmodule
`default_nettype wire

// file: design/mpd_top.sv
// motor parameter decode and start-path selection
// assumes speed-probe, probe and align results come from logic on the same clock;
// only the direction pin is asynchronous
`timescale 1ns/10ps
`default_nettype none
module mpd_top
    import mpd_pkg::*;
(
    // clock and reset
    input wire logic CLK_IN,
    input wire logic RST_N_IN,
    // configuration
    input wire logic [CODE_W-1:0] PHASE_RES_CODE_IN,
    input wire logic [CODE_W-1:0] BEMF_CONST_CODE_IN,
    input wire logic INITIAL_SPEED_PROBE_EN_IN,
    input wire logic RESYNC_EN_IN,
    input wire logic [THR_W-1:0] PROBE_CURRENT_THRESHOLD_IN,
    input wire logic [1:0] ALIGN_PHASE_IN,
    // start control and pin
    input wire logic START_IN,
    input wire logic DIR_PIN_IN,
    // speed probe results
    input wire logic SPEED_DONE_IN,
    input wire logic SPEED_MOVING_IN,
    input wire logic SPEED_FORWARD_IN,
    input wire logic SPEED_FAST_IN,
    input wire logic [2:0] SPEED_POSITION_IN,
    // rotor position probe and align results
    input wire logic PROBE_DONE_IN,
    input wire logic [2:0] PROBE_POSITION_IN,
    input wire logic ALIGN_DONE_IN,
    // decoded values
    output logic [LIN_W-1:0] PHASE_RES_LIN_OUT,
    output logic [LIN_W-1:0] BEMF_CONST_LIN_OUT,
    // sequencing
    output logic SPEED_PROBE_REQ_OUT,
    output logic POS_PROBE_REQ_OUT,
    output logic ALIGN_REQ_OUT,
    output logic [1:0] ALIGN_PHASE_OUT,
    output logic REVERSE_REQ_OUT,
    output logic CLOSED_LOOP_OUT,
    output logic COMMUT_LOAD_OUT,
    output logic [2:0] COMMUT_POS_OUT,
    output logic [1:0] START_PATH_OUT
);
    // ==========================================================
    // parameter decode
    logic [LIN_W-1:0] res_lin;
    logic [LIN_W-1:0] bemf_lin;

    // RL1 RL12 resistance decode
    mpd_code_decode u_res (
        .code_in(PHASE_RES_CODE_IN),
        .lin_out(res_lin)
    );

    // RL2 RL3 RL4 RL5 bemf decode
    mpd_code_decode u_bemf (
        .code_in(BEMF_CONST_CODE_IN),
        .lin_out(bemf_lin)
    );

    // ==========================================================
    // direction pin synchroniser and change detect
    logic dir_sync;
    mpd_sync2 u_dir (
        .clk_in(CLK_IN),
        .rst_n_in(RST_N_IN),
        .d_in(DIR_PIN_IN),
        .q_out(dir_sync)
    );

    // ==========================================================
    // state
    typedef struct packed {
        mpd_state_e st;
        mpd_path_e path;
        logic dir;
        logic load;
        logic [2:0] pos;
        logic [1:0] aphase;
        logic [LIN_W-1:0] res;
        logic [LIN_W-1:0] bemf;
    } mpd_state_s;

    mpd_state_s s_r;
    mpd_state_s s_nxt;
    logic dir_change;

    always_comb begin
        s_nxt = s_r;
        s_nxt.load = 1'b0;
        s_nxt.dir = dir_sync;
        dir_change = dir_sync != s_r.dir;
        // RL15 live decode latched at start
        if (s_r.st == ST_IDLE) begin
            s_nxt.res = res_lin;
            s_nxt.bemf = bemf_lin;
        end
        case (s_r.st)
            ST_IDLE: begin
                if (START_IN) begin
                    s_nxt.res = res_lin;
                    s_nxt.bemf = bemf_lin;
                    s_nxt.aphase = ALIGN_PHASE_IN;
                    if (INITIAL_SPEED_PROBE_EN_IN) begin
                        s_nxt.st = ST_SPEED;
                    end else begin
                        s_nxt.path = PATH_STILL;
                        // RL14 probe or align
                        s_nxt.st = (PROBE_CURRENT_THRESHOLD_IN != THR_OFF) ? ST_PROBE : ST_ALIGN;
                    end
                end
            end
            ST_SPEED: begin
                if (SPEED_DONE_IN) begin
                    // RL7 classify motor
                    if (!SPEED_MOVING_IN) begin
                        s_nxt.path = PATH_STILL;
                        s_nxt.st = (PROBE_CURRENT_THRESHOLD_IN != THR_OFF) ? ST_PROBE : ST_ALIGN;
                    end else if (SPEED_FORWARD_IN) begin
                        s_nxt.path = PATH_FWD;
                        // RL11 RL13 forward resync
                        if (RESYNC_EN_IN && SPEED_FAST_IN) begin
                            // RL13 position is only valid with done, so take it now
                            s_nxt.pos = SPEED_POSITION_IN;
                            s_nxt.st = ST_RESYNC;
                        end else begin
                            s_nxt.st = ST_SPEED;
                        end
                    end else begin
                        s_nxt.path = PATH_REV;
                        s_nxt.st = ST_REVERSE;
                    end
                end
            end
            ST_PROBE: begin
                // RL8 RL9 inductance probe position
                if (PROBE_DONE_IN) begin
                    s_nxt.pos = PROBE_POSITION_IN;
                    s_nxt.load = 1'b1;
                    s_nxt.st = ST_RUN;
                end
            end
            ST_ALIGN: begin
                // RL10 align to chosen phase
                if (ALIGN_DONE_IN) begin
                    s_nxt.pos = {1'b0, s_r.aphase};
                    s_nxt.load = 1'b1;
                    s_nxt.st = ST_RUN;
                end
            end
            ST_RESYNC: begin
                // RL11 load the seeded position and go straight to run
                s_nxt.load = 1'b1;
                s_nxt.st = ST_RUN;
            end
            ST_REVERSE: begin
                s_nxt.st = ST_REVERSE;
            end
            ST_RUN: begin
                s_nxt.st = ST_RUN;
            end
            default: begin
                s_nxt.st = ST_IDLE;
            end
        endcase
        if (dir_change && s_r.st != ST_IDLE) begin
            s_nxt.st = ST_IDLE;
            s_nxt.path = PATH_NONE;
            s_nxt.load = 1'b0;
        end
    end

    always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            s_r <= '{st: ST_IDLE, path: PATH_NONE, dir: 1'b0, load: 1'b0,
                     pos: 3'h0, aphase: PHASE_RST, res: 11'h000, bemf: 11'h000};
        end else begin
            s_r <= s_nxt;
        end
    end

    // ==========================================================
    // outputs
    assign PHASE_RES_LIN_OUT = s_r.res;
    assign BEMF_CONST_LIN_OUT = s_r.bemf;
    assign SPEED_PROBE_REQ_OUT = s_r.st == ST_SPEED;
    assign POS_PROBE_REQ_OUT = s_r.st == ST_PROBE;
    assign ALIGN_REQ_OUT = s_r.st == ST_ALIGN;
    assign ALIGN_PHASE_OUT = s_r.aphase;
    assign REVERSE_REQ_OUT = s_r.st == ST_REVERSE;
    assign CLOSED_LOOP_OUT = s_r.st == ST_RUN;
    assign COMMUT_LOAD_OUT = s_r.load;
    assign COMMUT_POS_OUT = s_r.pos;
    assign START_PATH_OUT = s_r.path;

    // ==========================================================
    // checks
    a_bemf_max: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN) // RL4
        (BEMF_CONST_CODE_IN == CODE_MAX) |-> (bemf_lin == LIN_MAX))
        else $error("bemf max code wrong");
    a_bemf_min: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN) // RL5
        (BEMF_CONST_CODE_IN == 7'h01) |-> (bemf_lin == 11'h001))
        else $error("bemf min code wrong");
    a_res_zero: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN) // RL1
        (PHASE_RES_CODE_IN == 7'h00) |-> (res_lin == 11'h000))
        else $error("resistance zero code wrong");
    a_res_shift: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN) // RL12
        (PHASE_RES_CODE_IN == 7'h3A) |-> (res_lin == 11'h050))
        else $error("resistance shift wrong");
    a_res_max: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN) // RL1
        (PHASE_RES_CODE_IN == CODE_MAX) |-> (res_lin == LIN_MAX))
        else $error("resistance max code wrong");
    a_res_one: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN) // RL1
        (PHASE_RES_CODE_IN == 7'h01) |-> (res_lin == 11'h001))
        else $error("resistance one step wrong");
    a_bemf_zero: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN) // RL3
        (BEMF_CONST_CODE_IN == 7'h00) |-> (bemf_lin == 11'h000))
        else $error("bemf zero code wrong");
    a_bemf_shift: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN) // RL3
        (BEMF_CONST_CODE_IN == 7'h6A) |-> (bemf_lin == 11'h280))
        else $error("bemf shift wrong");

    // ==========================================================
    // decoded value and align phase hold checks
    a_lin_track: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN) // RL15
        (s_r.st == ST_IDLE) |=>
            (PHASE_RES_LIN_OUT == $past(res_lin)) && (BEMF_CONST_LIN_OUT == $past(bemf_lin)))
        else $error("decoded values not tracking in idle");
    a_lin_frozen: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN) // RL15
        (s_r.st != ST_IDLE) |=> $stable(PHASE_RES_LIN_OUT) && $stable(BEMF_CONST_LIN_OUT))
        else $error("decoded values moved after start");
    a_phase_frozen: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN) // RL10
        (s_r.st != ST_IDLE) |=> $stable(ALIGN_PHASE_OUT))
        else $error("align phase moved after start");
    a_phase_taken: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN) // RL10
        (s_r.st == ST_IDLE && START_IN) |=> (ALIGN_PHASE_OUT == $past(ALIGN_PHASE_IN)))
        else $error("align phase not taken at start");

    // ==========================================================
    // start-path checks
    a_resync_path: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN) // RL13
        (s_r.st == ST_RESYNC) |-> $past(SPEED_FORWARD_IN) && $past(RESYNC_EN_IN))
        else $error("resync without forward probe");
    a_probe_sel: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN) // RL14
        (s_r.st == ST_IDLE && START_IN && !INITIAL_SPEED_PROBE_EN_IN && !dir_change &&
         PROBE_CURRENT_THRESHOLD_IN == THR_OFF) |=> ALIGN_REQ_OUT)
        else $error("align not chosen");
    a_align_pos: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN) // RL10
        (s_r.st == ST_ALIGN && ALIGN_DONE_IN && !dir_change) |=>
            COMMUT_LOAD_OUT && COMMUT_POS_OUT == {1'b0, ALIGN_PHASE_OUT} ##1 !COMMUT_LOAD_OUT)
        else $error("align position not loaded");
    a_still_load: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN) // RL8
        $rose(CLOSED_LOOP_OUT) |-> COMMUT_LOAD_OUT)
        else $error("run without commutation load");
    a_rev_path: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN) // RL7
        REVERSE_REQ_OUT |-> START_PATH_OUT == PATH_REV)
        else $error("reverse path mismatch");
    a_speed_first: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN) // RL13
        (s_r.st == ST_IDLE && START_IN && INITIAL_SPEED_PROBE_EN_IN) |=> SPEED_PROBE_REQ_OUT)
        else $error("speed probe not started");
    a_probe_first: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN) // RL14
        (s_r.st == ST_IDLE && START_IN && !INITIAL_SPEED_PROBE_EN_IN &&
         PROBE_CURRENT_THRESHOLD_IN != THR_OFF) |=> POS_PROBE_REQ_OUT)
        else $error("rotor probe not chosen");
    a_still_sel: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN) // RL7 RL14
        (s_r.st == ST_SPEED && SPEED_DONE_IN && !SPEED_MOVING_IN && !dir_change) |=>
            (START_PATH_OUT == PATH_STILL) && (POS_PROBE_REQ_OUT == $past(PROBE_CURRENT_THRESHOLD_IN != THR_OFF)) &&
            (ALIGN_REQ_OUT == !POS_PROBE_REQ_OUT))
        else $error("stationary path not chosen");
    a_rev_sel: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN) // RL7
        (s_r.st == ST_SPEED && SPEED_DONE_IN && SPEED_MOVING_IN && !SPEED_FORWARD_IN && !dir_change) |=>
            REVERSE_REQ_OUT && (START_PATH_OUT == PATH_REV))
        else $error("reverse path not chosen");
    a_fwd_hold: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN) // RL11
        (s_r.st == ST_SPEED && SPEED_DONE_IN && SPEED_MOVING_IN && SPEED_FORWARD_IN &&
         !(RESYNC_EN_IN && SPEED_FAST_IN) && !dir_change) |=> SPEED_PROBE_REQ_OUT && (START_PATH_OUT == PATH_FWD))
        else $error("forward without resync left speed probe");
    a_resync_pos: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN) // RL11 RL13
        (s_r.st == ST_SPEED && SPEED_DONE_IN && SPEED_MOVING_IN && SPEED_FORWARD_IN && RESYNC_EN_IN &&
         SPEED_FAST_IN && !dir_change) ##1 !dir_change |=>
            CLOSED_LOOP_OUT && COMMUT_LOAD_OUT && (COMMUT_POS_OUT == $past(SPEED_POSITION_IN, 2)))
        else $error("resync position not seeded");
    a_probe_pos: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN) // RL9
        (s_r.st == ST_PROBE && PROBE_DONE_IN && !dir_change) |=>
            CLOSED_LOOP_OUT && COMMUT_LOAD_OUT && (COMMUT_POS_OUT == $past(PROBE_POSITION_IN)))
        else $error("probe position not loaded");
    a_load_pulse: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN) // RL8
        COMMUT_LOAD_OUT |=> !COMMUT_LOAD_OUT)
        else $error("commutation load longer than one cycle");
    a_dir_abort: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN) // RL7
        (dir_change && s_r.st != ST_IDLE) |=> !SPEED_PROBE_REQ_OUT && !POS_PROBE_REQ_OUT && !ALIGN_REQ_OUT &&
            !REVERSE_REQ_OUT && !CLOSED_LOOP_OUT && (START_PATH_OUT == PATH_NONE))
        else $error("direction change did not restart");
    a_run_holds: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN) // RL11
        (CLOSED_LOOP_OUT && !dir_change) |=> CLOSED_LOOP_OUT)
        else $error("closed loop dropped");
    a_rev_holds: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN) // RL7
        (REVERSE_REQ_OUT && !dir_change) |=> REVERSE_REQ_OUT)
        else $error("reverse request dropped");
    a_still_only: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN) // RL8
        (POS_PROBE_REQ_OUT || ALIGN_REQ_OUT) |-> (START_PATH_OUT == PATH_STILL))
        else $error("probe or align outside stationary path");
endmodule
`default_nettype wire

// file: testbench/mpd_motor_model.sv
// sensorless motor model: answers speed probe, rotor probe and align requests
// assumes requests are levels held until the matching done pulse
`timescale 1ns/10ps
`default_nettype none
module mpd_motor_model (
    // clock, reset and requests
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic spd_req_in,
    input wire logic prb_req_in,
    input wire logic aln_req_in,
    // motor condition {moving, forward, fast}, rotor position, answer delay
    input wire logic [2:0] cond_in,
    input wire logic [2:0] pos_in,
    input wire logic [3:0] dly_in,
    // answers
    output logic spd_done_out,
    output logic prb_done_out,
    output logic aln_done_out,
    output logic [2:0] cond_out,
    output logic [2:0] pos_out
);
    logic [3:0] cnt_r;
    logic any_req;
    logic busy;
    logic hit;
    assign any_req = spd_req_in | prb_req_in | aln_req_in;
    assign busy = spd_done_out | prb_done_out | aln_done_out;
    assign hit = any_req && !busy && cnt_r == dly_in;
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cnt_r <= 4'h0;
            spd_done_out <= 1'b0;
            prb_done_out <= 1'b0;
            aln_done_out <= 1'b0;
            cond_out <= 3'h0;
            pos_out <= 3'h0;
        end else begin
            cnt_r <= (any_req && !busy && !hit) ? cnt_r + 4'h1 : 4'h0;
            spd_done_out <= hit & spd_req_in;
            prb_done_out <= hit & prb_req_in;
            aln_done_out <= hit & aln_req_in;
            // results valid only with done, garbage otherwise
            cond_out <= hit ? cond_in : ~cond_in;
            pos_out <= hit ? pos_in : ~pos_in;
        end
    end
endmodule
`default_nettype wire

// file: testbench/motor_param_decode_start_select_tb.sv
// testbench for the parameter decoder and start-path selector
// assumes the motor model drives all speed, probe and align results
`timescale 1ns/10ps
`default_nettype none
module motor_param_decode_start_select_tb;
    import mpd_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [6:0] res_code = 7'h00;
    logic [6:0] bemf_code = 7'h00;
    logic sp_en = 1'b0;
    logic rs_en = 1'b0;
    logic [3:0] thr = 4'h0;
    logic start = 1'b0;
    logic dir = 1'b0;
    logic [2:0] cond = 3'h0;
    logic [3:0] dly = 4'h0;
    logic [1:0] aph = 2'h2;
    logic [10:0] res_lin, bemf_lin;
    logic spd_req, prb_req, aln_req, rev_req, cl, load, spd_done, prb_done, aln_done;
    logic [1:0] aln_ph, path, ph_seen;
    logic [2:0] cpos, mcond, mpos;
    logic [3:0] s;
    // stimulus uses valid codes only; lins holds their linear weights
    logic [6:0] codes [8] = '{7'h00, 7'h01, 7'h02, 7'h0F, 7'h18, 7'h4F, 7'h6A, 7'h7F};
    logic [10:0] lins [8] = '{11'h000, 11'h001, 11'h002, 11'h00F, 11'h010, 11'h0F0, 11'h280, 11'h780};
    int n_errors = 0;
    int num_checks = 0;
    always #4 clk = ~clk;
    mpd_top dut (.CLK_IN(clk), .RST_N_IN(rst_n), .PHASE_RES_CODE_IN(res_code), .BEMF_CONST_CODE_IN(bemf_code),
        .INITIAL_SPEED_PROBE_EN_IN(sp_en), .RESYNC_EN_IN(rs_en), .PROBE_CURRENT_THRESHOLD_IN(thr),
        .ALIGN_PHASE_IN(aph), .START_IN(start), .DIR_PIN_IN(dir), .SPEED_DONE_IN(spd_done),
        .SPEED_MOVING_IN(mcond[2]), .SPEED_FORWARD_IN(mcond[1]), .SPEED_FAST_IN(mcond[0]),
        .SPEED_POSITION_IN(mpos), .PROBE_DONE_IN(prb_done), .PROBE_POSITION_IN(mpos), .ALIGN_DONE_IN(aln_done),
        .PHASE_RES_LIN_OUT(res_lin), .BEMF_CONST_LIN_OUT(bemf_lin), .SPEED_PROBE_REQ_OUT(spd_req),
        .POS_PROBE_REQ_OUT(prb_req), .ALIGN_REQ_OUT(aln_req), .ALIGN_PHASE_OUT(aln_ph), .REVERSE_REQ_OUT(rev_req),
        .CLOSED_LOOP_OUT(cl), .COMMUT_LOAD_OUT(load), .COMMUT_POS_OUT(cpos), .START_PATH_OUT(path));
    mpd_motor_model motor (.clk_in(clk), .rst_n_in(rst_n), .spd_req_in(spd_req), .prb_req_in(prb_req),
        .aln_req_in(aln_req), .cond_in(cond), .pos_in(3'h5), .dly_in(dly), .spd_done_out(spd_done),
        .prb_done_out(prb_done), .aln_done_out(aln_done), .cond_out(mcond), .pos_out(mpos));
    // ====================
    // tasks
    task automatic results();
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [10:0] exp, input logic [10:0] got);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("Error %s expected %0h seen %0h", what, exp, got);
        end
    endtask
    // reset, configure, pulse start, wait for load or reverse request; with hold expect neither
    task automatic go(input logic sp, input logic [3:0] th, input logic [3:0] c, input logic [3:0] d,
        input logic [1:0] ap, input logic hold);
        int i;
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        sp_en <= sp;
        thr <= th;
        {rs_en, cond} <= c;
        dly <= d;
        aph <= ap;
        s = 4'h0;
        @(posedge clk);
        start <= 1'b1;
        @(posedge clk);
        start <= 1'b0;
        for (i = 0; i < (hold ? 20 : 60) && s[0] !== 1'b1; i++) begin
            @(negedge clk);
            s[3:1] = s[3:1] | {spd_req, prb_req, aln_req};
            if (aln_req === 1'b1) begin
                ph_seen = aln_ph;
            end
            s[0] = load | rev_req;
        end
        if (hold) begin
            chk("no load while held", 11'h0, 11'(s[0]));
        end else if (s[0] !== 1'b1) begin
            n_errors++;
            $display("Error start wait expected load seen none");
            results();
        end
    endtask
    task automatic ends(input string name, input logic [1:0] p, input logic [2:0] pos);
        chk("path", 11'(p), 11'(path));
        chk("commut pos", 11'(pos), 11'(cpos));
        chk("closed loop", 11'h1, 11'(cl));
        @(negedge clk);
        chk("load pulse", 11'h0, 11'(load));
        $display("test %s done, errors %0d", name, n_errors);
    endtask
    // ====================
    // sequence
    initial begin
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        foreach (codes[k]) begin
            @(posedge clk);
            res_code <= codes[k];
            bemf_code <= codes[7-k];
            repeat (2) @(posedge clk);
            @(negedge clk);
            chk("phase res lin", lins[k], res_lin);
            chk("bemf lin", lins[7-k], bemf_lin);
        end
        $display("test decode done, errors %0d", n_errors);
        go(1'b0, 4'h0, 4'h0, 4'h0, 2'h2, 1'b0);
        chk("align phase", 11'h2, 11'(ph_seen));
        ends("align", 2'h1, 3'h2);
        go(1'b0, 4'h3, 4'h0, 4'h9, 2'h2, 1'b0);
        chk("probe only", 11'h2, 11'(s[3:1]));
        ends("probe", 2'h1, 3'h5);
        go(1'b1, 4'h0, 4'h8, 4'h2, 2'h1, 1'b0);
        chk("speed then align", 11'h5, 11'(s[3:1]));
        chk("align phase", 11'h1, 11'(ph_seen));
        ends("still", 2'h1, 3'h1);
        go(1'b1, 4'h3, 4'hF, 4'h0, 2'h2, 1'b0);
        chk("no probe no align", 11'h4, 11'(s[3:1]));
        ends("resync", 2'h2, 3'h5);
        go(1'b1, 4'h3, 4'h7, 4'h0, 2'h2, 1'b1);
        chk("fwd no resync path", 11'h2, 11'(path));
        chk("fwd no resync req", 11'h1, 11'(spd_req));
        go(1'b1, 4'h3, 4'hE, 4'h0, 2'h2, 1'b1);
        chk("fwd slow path", 11'h2, 11'(path));
        chk("fwd slow req", 11'h1, 11'(spd_req));
        $display("test forward hold done, errors %0d", n_errors);
        go(1'b1, 4'h3, 4'hD, 4'h1, 2'h2, 1'b0);
        @(posedge clk);
        res_code <= 7'h3A;
        repeat (2) @(posedge clk);
        @(negedge clk);
        chk("reverse path", 11'h3, 11'(path));
        chk("no load", 11'h0, 11'(load));
        chk("frozen lin", 11'h780, res_lin);
        @(posedge clk);
        dir <= 1'b1;
        repeat (8) @(posedge clk);
        @(negedge clk);
        chk("abort", 11'h0, 11'(rev_req));
        chk("new lin", 11'h050, res_lin);
        $display("test reverse done, errors %0d", n_errors);
        results();
    end
endmodule
`default_nettype wire
